// ---- rtl/rf_status_readout.sv ----
// status and test readout register bank of the transceiver
// assumes analog/core status inputs are asynchronous and are synchronised
// here; the register port is synchronous to clk_i
`timescale 1ns/1ns
module rf_status_readout #(
  parameter logic [2:0] CHIP_REVISION = rf_status_pkg::CHIP_REVISION_VALUE
) (
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  input  wire logic [6:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  input  wire logic       cal_start_i,
  input  wire logic       cal_end_i,
  input  wire logic       powerup_lock_fail_i,
  input  wire logic       lock_now_i,
  input  wire logic       lock_filtered_i,
  input  wire logic [6:0] signal_strength_i,
  input  wire logic [6:0] carrier_threshold_i,
  input  wire logic       lock_pin_i,
  input  wire logic       data_clock_pin_i,
  input  wire logic       data_io_pin_i,
  input  wire logic [7:0] init_ok_i,
  input  wire logic [7:0] freq_offset_avg_i,
  input  wire logic [7:0] freq_offset_instant_i,
  input  wire logic [3:0] cal_dac_i,
  input  wire logic [3:0] pump_current_value_i,
  input  wire logic [4:0] osc_array_value_i,
  input  wire logic       phase_freq_comp_i,
  input  wire logic       osc_current_comparator_i,
  input  wire logic [5:0] osc_cal_current_value_i,
  input  wire logic [1:0] converter_mix_i,
  input  wire logic [2:0] converter_i_i,
  input  wire logic [2:0] converter_q_i,
  input  wire logic [7:0] chan_filter_i_i,
  output logic      [1:0] amp_stage1_override_o,
  output logic      [1:0] amp_stage2_override_o,
  output logic      [1:0] amp_stage3_override_o
);

  localparam int SYN_W = 83;

  // ==========================================================
  // input synchronisers
  logic [SYN_W-1:0] raw_in;
  logic [SYN_W-1:0] sync_a;
  logic [SYN_W-1:0] sync_b;

  assign raw_in = {cal_start_i, cal_end_i, powerup_lock_fail_i, lock_now_i,
                   lock_filtered_i, signal_strength_i, carrier_threshold_i,
                   lock_pin_i, data_clock_pin_i, data_io_pin_i, init_ok_i,
                   freq_offset_avg_i, freq_offset_instant_i, cal_dac_i,
                   pump_current_value_i, osc_array_value_i,
                   phase_freq_comp_i, osc_current_comparator_i,
                   osc_cal_current_value_i, converter_mix_i, converter_i_i,
                   converter_q_i, chan_filter_i_i};

  // multi-bit values may tear for one sample; readouts are diagnostic only
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= raw_in;
      sync_b <= sync_a;
    end
  end

  logic       s_cal_start;
  logic       s_cal_end;
  logic       s_lock_fail;
  logic       s_lock_now;
  logic       s_lock_filt;
  logic [6:0] s_strength;
  logic [6:0] s_threshold;
  logic [2:0] s_pins;
  logic [7:0] s_init;
  logic [7:0] s_avg;
  logic [7:0] s_inst;
  logic [7:0] s_cal_pump;
  logic [4:0] s_osc_array;
  logic [7:0] s_osc_cal;
  logic [7:0] s_conv;
  logic [7:0] s_filt;

  assign {s_cal_start, s_cal_end, s_lock_fail, s_lock_now, s_lock_filt,
          s_strength, s_threshold, s_pins, s_init, s_avg, s_inst,
          s_cal_pump, s_osc_array, s_osc_cal, s_conv, s_filt} = sync_b;

  // ==========================================================
  // status flags
  logic       cal_done;
  logic       lock_fail_seen;
  logic       avg_valid;

  // a fresh start beats an end seen in the same cycle
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cal_done <= 1'b0;
    end else if (s_cal_start) begin
      cal_done <= 1'b0;
    end else if (s_cal_end) begin
      cal_done <= 1'b1;
    end
  end

  // sticky until the next calibration start, which begins a new sequence
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lock_fail_seen <= 1'b0;
    end else if (s_lock_fail) begin
      lock_fail_seen <= 1'b1;
    end else if (s_cal_start) begin
      lock_fail_seen <= 1'b0;
    end
  end

  // averaged offset reads its reset value until the filter has reset
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      avg_valid <= 1'b0;
    end else begin
      avg_valid <= s_init[4];
    end
  end

  // ==========================================================
  // register views
  logic [7:0] status_view;
  logic [7:0] avg_view;

  always_comb begin
    status_view = {cal_done,
                   lock_fail_seen,
                   s_lock_now,
                   s_lock_filt,
                   s_strength > s_threshold,
                   s_pins};
    avg_view = avg_valid ? s_avg : rf_status_pkg::FREQ_AVG_RESET;
  end

  // ==========================================================
  // override register
  logic [7:0] amp_override;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      amp_override <= rf_status_pkg::AMP_OVERRIDE_RESET;
    end else if (wr_i && addr_i == rf_status_pkg::AMP_STAGE_OVERRIDE_ADDR) begin
      // reserved bits are dropped so they always read zero
      amp_override <= wdata_i & rf_status_pkg::AMP_OVERRIDE_MASK;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      amp_stage1_override_o <= 2'h0;
      amp_stage2_override_o <= 2'h0;
      amp_stage3_override_o <= 2'h0;
    end else begin
      amp_stage1_override_o <= amp_override[5:4];
      amp_stage2_override_o <= amp_override[3:2];
      amp_stage3_override_o <= amp_override[1:0];
    end
  end

  // ==========================================================
  // read port; other writes fall through with no effect
  logic [7:0] next_rdata;

  always_comb begin
    unique case (addr_i)
      rf_status_pkg::AMP_STAGE_OVERRIDE_ADDR:  next_rdata = amp_override;
      rf_status_pkg::PLL_RX_FLAGS_ADDR:        next_rdata = status_view;
      rf_status_pkg::SUBBLOCK_INIT_FLAGS_ADDR: next_rdata = s_init;
      rf_status_pkg::SIGNAL_STRENGTH_ADDR:
        next_rdata = {1'b0, s_strength};
      rf_status_pkg::FREQ_OFFSET_AVG_ADDR:     next_rdata = avg_view;
      rf_status_pkg::FREQ_OFFSET_INSTANT_ADDR: next_rdata = s_inst;
      rf_status_pkg::CAL_PUMP_ADDR:            next_rdata = s_cal_pump;
      rf_status_pkg::REV_OSC_ARRAY_ADDR:
        next_rdata = {CHIP_REVISION, s_osc_array};
      rf_status_pkg::OSC_CAL_ADDR:             next_rdata = s_osc_cal;
      rf_status_pkg::CONVERTER_SAMPLE_ADDR:    next_rdata = s_conv;
      rf_status_pkg::CHAN_FILTER_I_ADDR:       next_rdata = s_filt;
      default:                                 next_rdata = rf_status_pkg::ZERO_BYTE;
    endcase
  end

  // reads are pure; nothing above depends on rd_i
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_o <= rf_status_pkg::ZERO_BYTE;
    end else if (rd_i) begin
      rdata_o <= next_rdata;
    end else begin
      rdata_o <= rf_status_pkg::ZERO_BYTE;
    end
  end

endmodule

// ---- rtl/rf_status_pkg.sv ----
// constants for the status and test readout register bank
// assumes an 8-bit register port with 7-bit addresses and one clock
// Function
// - calibration-done status bit 7 clears when calibration starts and sets when it ends.
// - status bit 6 sets when lock fails during the automatic power-up sequence.
// - status bit 5 shows the raw instantaneous lock indication.
// - status bit 4 shows lock per the selected lock-window accuracy.
// - status bit 3 is carrier present when signal strength exceeds the threshold.
// - status bits 2, 1, 0 show the lock, data clock and data io pin levels.
// - the init flags register holds eight sub-block reset-complete flags.
// - signal strength reads a 7-bit value in bits 6:0 with bit 7 zero.
// - averaged frequency offset reads an 8-bit signed decision level.
// - instantaneous frequency offset reads a signed 8-bit value.
// - cal pump readout gives cal dac in 7:4 and pump current in 3:0.
// - revision readout gives chip revision in 7:5 and osc array in 4:0.
// - osc cal readout gives comparators in 7 and 6 and cal current in 5:0.
// - converter readout gives mixer input 7:6, in-phase 5:3, quadrature 2:0.
// - channel filter readout gives the top eight in-phase bits.
// - amp override holds three 2-bit stage overrides, reset 0, reserved 7:6.
package rf_status_pkg;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;

  // ==========================================================
  // register offsets
  localparam logic [6:0] AMP_STAGE_OVERRIDE_ADDR  = 7'h27;
  localparam logic [6:0] PLL_RX_FLAGS_ADDR        = 7'h40;
  localparam logic [6:0] SUBBLOCK_INIT_FLAGS_ADDR = 7'h41;
  localparam logic [6:0] SIGNAL_STRENGTH_ADDR     = 7'h42;
  localparam logic [6:0] FREQ_OFFSET_AVG_ADDR     = 7'h43;
  localparam logic [6:0] FREQ_OFFSET_INSTANT_ADDR = 7'h44;
  localparam logic [6:0] CAL_PUMP_ADDR            = 7'h45;
  localparam logic [6:0] REV_OSC_ARRAY_ADDR       = 7'h46;
  localparam logic [6:0] OSC_CAL_ADDR             = 7'h47;
  localparam logic [6:0] CONVERTER_SAMPLE_ADDR    = 7'h48;
  localparam logic [6:0] CHAN_FILTER_I_ADDR       = 7'h49;

  // ==========================================================
  // reset values and fields
  localparam logic [7:0] AMP_OVERRIDE_RESET  = 8'h00;
  localparam logic [7:0] AMP_OVERRIDE_MASK   = 8'h3F;
  localparam logic [7:0] FREQ_AVG_RESET      = 8'h01;
  localparam logic [7:0] ZERO_BYTE           = 8'h00;
  localparam logic [2:0] CHIP_REVISION_VALUE = 3'h2; // arbitrary value
endpackage

// ---- tb/rf_status_readout_chk.sv ----
// checker for the status readout bank, bound to the bank's ports
// assumes one clock and status inputs held steady around a judged read
`timescale 1ns/1ns
module rf_status_readout_chk (
  input wire logic       clk_i,
  input wire logic       reset_n_i,
  input wire logic [6:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic [6:0] signal_strength_i,
  input wire logic [6:0] carrier_threshold_i,
  input wire logic [7:0] init_ok_i,
  input wire logic [1:0] amp_stage1_override_o,
  input wire logic [1:0] amp_stage2_override_o,
  input wire logic [1:0] amp_stage3_override_o
);
  logic [1:0] age;
  wire  [5:0] ovr = {amp_stage1_override_o, amp_stage2_override_o,
                     amp_stage3_override_o};
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // =====
  // status inputs cross two sync flops, so judge only settled reads
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i)
      age <= 2'h0;
    else if (age != 2'h3)
      age <= age + 2'h1;
  end
  sequence s_quiet;
    (age == 2'h3 && $stable({signal_strength_i, carrier_threshold_i,
                             init_ok_i}))[*3];
  endsequence
  sequence s_rd(logic [6:0] a);
    rd_i && addr_i == a;
  endsequence
  sequence s_ovr_wr;
    wr_i && addr_i == 7'h27;
  endsequence
  // =====
  AST_RD_IDLE: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data not zero outside a read");
  AST_UNMAPPED: assert property (rd_i && (addr_i < 7'h27 || addr_i > 7'h49
    || (addr_i > 7'h27 && addr_i < 7'h40)) |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  AST_OVR_RSV: assert property (s_rd(7'h27) |=> rdata_o[7:6] == 2'h0)
    else $error("override reserved bits not zero");
  AST_OVR_WR: assert property (s_ovr_wr |=> ##1
    {2'h0, ovr} == ($past(wdata_i, 2) & 8'h3F))
    else $error("override outputs do not follow write");
  AST_OVR_HOLD: assert property (!wr_i ##1 !wr_i |=> $stable(ovr))
    else $error("override outputs moved without write");
  AST_CARRIER: assert property (s_quiet ##0 s_rd(7'h40) |=>
    rdata_o[3] == ($past(signal_strength_i) > $past(carrier_threshold_i)))
    else $error("carrier flag wrong");
  AST_STRENGTH: assert property (s_quiet ##0 s_rd(7'h42) |=>
    rdata_o == {1'b0, $past(signal_strength_i)})
    else $error("signal strength readout wrong");
  AST_INIT: assert property (s_quiet ##0 s_rd(7'h41) |=>
    rdata_o == $past(init_ok_i))
    else $error("init flags readout wrong");
endmodule

bind rf_status_readout rf_status_readout_chk i_chk (
  .clk_i, .reset_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
  .signal_strength_i, .carrier_threshold_i, .init_ok_i,
  .amp_stage1_override_o, .amp_stage2_override_o, .amp_stage3_override_o
);

// ---- tb/tb_top.sv ----
// self-checking bench for the status readout bank
// assumes the bank alone, with its checker bound to it
`timescale 1ns/1ns
module tb_top;
  localparam logic [2:0] REV = 3'h5; // arbitrary value
  localparam logic [7:0] PATS [4] = '{8'hA5, 8'h5A, 8'hC0, 8'hFF};
  logic clk_i = 1'b0, reset_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  logic cal_start_i = 1'b0, cal_end_i = 1'b0, powerup_lock_fail_i = 1'b0;
  logic lock_now_i = 1'b0, lock_filtered_i = 1'b0, lock_pin_i = 1'b0;
  logic data_clock_pin_i = 1'b0, data_io_pin_i = 1'b0;
  logic phase_freq_comp_i = 1'b0, osc_current_comparator_i = 1'b0;
  logic [6:0] addr_i = 7'h00, signal_strength_i = 7'h00;
  logic [6:0] carrier_threshold_i = 7'h40;
  logic [7:0] wdata_i = 8'h00, init_ok_i = 8'h00, freq_offset_avg_i = 8'h00;
  logic [7:0] freq_offset_instant_i = 8'h00, chan_filter_i_i = 8'h00;
  logic [3:0] cal_dac_i = 4'h0, pump_current_value_i = 4'h0;
  logic [4:0] osc_array_value_i = 5'h00;
  logic [5:0] osc_cal_current_value_i = 6'h00;
  logic [2:0] converter_i_i = 3'h0, converter_q_i = 3'h0;
  logic [1:0] converter_mix_i = 2'h0, hi = 2'h0;
  logic [7:0] rdata_o, ovr = 8'h00;
  logic [1:0] amp_stage1_override_o, amp_stage2_override_o;
  logic [1:0] amp_stage3_override_o;
  int error_cnt = 0, samples_checked = 0;
  rf_status_readout #(.CHIP_REVISION(REV)) i_dut (
    .clk_i, .reset_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .cal_start_i, .cal_end_i, .powerup_lock_fail_i, .lock_now_i,
    .lock_filtered_i, .signal_strength_i, .carrier_threshold_i,
    .lock_pin_i, .data_clock_pin_i, .data_io_pin_i, .init_ok_i,
    .freq_offset_avg_i, .freq_offset_instant_i, .cal_dac_i,
    .pump_current_value_i, .osc_array_value_i, .phase_freq_comp_i,
    .osc_current_comparator_i, .osc_cal_current_value_i,
    .converter_mix_i, .converter_i_i, .converter_q_i, .chan_filter_i_i,
    .amp_stage1_override_o, .amp_stage2_override_o, .amp_stage3_override_o);
  always #2 clk_i = ~clk_i;
  // =====
  function automatic logic [7:0] exp_of(input logic [6:0] a);
    case (a)
      7'h27: exp_of = ovr;
      7'h40: exp_of = {hi, lock_now_i, lock_filtered_i,
        signal_strength_i > carrier_threshold_i, lock_pin_i,
        data_clock_pin_i, data_io_pin_i};
      7'h41: exp_of = init_ok_i;
      7'h42: exp_of = {1'b0, signal_strength_i};
      7'h43: exp_of = init_ok_i[4] ? freq_offset_avg_i : 8'h01;
      7'h44: exp_of = freq_offset_instant_i;
      7'h45: exp_of = {cal_dac_i, pump_current_value_i};
      7'h46: exp_of = {REV, osc_array_value_i};
      7'h47: exp_of = {phase_freq_comp_i, osc_current_comparator_i,
        osc_cal_current_value_i};
      7'h48: exp_of = {converter_mix_i, converter_i_i, converter_q_i};
      7'h49: exp_of = chan_filter_i_i;
      default: exp_of = 8'h00;
    endcase
  endfunction
  task chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task rd_chk(input logic [6:0] a);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, exp_of(a));
  endtask
  task rd_all;
    for (logic [7:0] a = 8'h40; a <= 8'h49; a++)
      rd_chk(a[6:0]);
  endtask
  task chk_ovr;
    chk({2'h0, amp_stage1_override_o, amp_stage2_override_o,
         amp_stage3_override_o}, ovr);
  endtask
  task pulse(input int k);
    @(posedge clk_i);
    case (k)
      0: cal_start_i <= 1'b1;
      1: cal_end_i <= 1'b1;
      2: powerup_lock_fail_i <= 1'b1;
      default: {cal_start_i, cal_end_i, powerup_lock_fail_i} <= 3'h7;
    endcase
    @(posedge clk_i);
    {cal_start_i, cal_end_i, powerup_lock_fail_i} <= 3'h0;
    repeat (3) @(posedge clk_i);
  endtask
  task print_verdict;
    $display("checked %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // =====
  task t_reset;
    rd_chk(7'h27);
    rd_all();
  endtask
  task t_override;
    wr(7'h27, 8'hFF);
    ovr = 8'h3F;
    rd_chk(7'h27);
    chk_ovr();
    wr(7'h27, 8'h9B);
    ovr = 8'h1B;
    wr(7'h40, 8'hFF);
    wr(7'h42, 8'hFF);
    wr(7'h30, 8'hAA);
    rd_chk(7'h27);
    chk_ovr();
    rd_chk(7'h30);
    rd_chk(7'h7F);
    rd_all();
  endtask
  task t_cal;
    pulse(1);
    hi = 2'h2;
    rd_chk(7'h40);
    pulse(2);
    hi = 2'h3;
    rd_chk(7'h40);
    rd_chk(7'h40);
    pulse(0);
    hi = 2'h0;
    rd_chk(7'h40);
    pulse(3);
    hi = 2'h1;
    rd_chk(7'h40);
    pulse(1);
    hi = 2'h3;
    rd_chk(7'h40);
  endtask
  task t_rerst;
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    ovr = 8'h00;
    hi = 2'h0;
    #1 chk_ovr();
    rd_chk(7'h27);
    repeat (4) @(posedge clk_i);
    rd_all();
  endtask
  task t_fields;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i);
      {lock_now_i, lock_filtered_i, lock_pin_i} <= PATS[i][4:2];
      {data_clock_pin_i, data_io_pin_i} <= PATS[i][1:0];
      {phase_freq_comp_i, osc_current_comparator_i} <= ~PATS[i][7:6];
      osc_cal_current_value_i <= ~PATS[i][5:0];
      signal_strength_i <= PATS[i][6:0];
      {init_ok_i, freq_offset_avg_i} <= {PATS[i], ~PATS[i]};
      freq_offset_instant_i <= PATS[i] ^ 8'h3C;
      {cal_dac_i, pump_current_value_i} <= ~PATS[i];
      osc_array_value_i <= PATS[i][7:3];
      {converter_mix_i, converter_i_i, converter_q_i} <= PATS[i];
      chan_filter_i_i <= {PATS[i][3:0], PATS[i][7:4]};
      repeat (4) @(posedge clk_i);
      rd_all();
    end
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    reset_n_i <= 1'b1;
    t_reset();
    t_override();
    t_cal();
    t_fields();
    t_rerst();
    print_verdict();
  end
  // the whole run needs well under a thousand cycles
  initial begin
    #20000;
    error_cnt++;
    print_verdict();
  end
endmodule
